// *** hw/ides_slave.sv ***
// ides_slave: slave end answering as register device and byte-addressed memory
// assumes the master owns scl; pins are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none
module ides_slave (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus
  ides_if.dev bus,
  // address straps and protect pin
  input wire logic fixed_slave_addr_pin,
  input wire logic [5:0] soft_slave_addr_pins,
  input wire logic [2:0] soft_pin_count,
  input wire logic mem_write_protect_in,
  // register device side
  output logic [7:0] reg_ptr,
  output logic reg_ptr_stb,
  output logic [7:0] reg_wr_data,
  output logic reg_wr_stb,
  input wire logic [7:0] reg_rd_data,
  output logic reg_rd_stb
);
  ides_pkg::ides_slave_e state; // bit-level state
  logic scl_a, scl_b, scl_q; // scl sync chain and delay
  logic sda_a, sda_b, sda_q; // sda sync chain and delay
  logic [10:0] pin_a, pin_b; // pin sync chain
  logic [2:0] bit_cnt; // bit within byte
  logic [7:0] shreg; // receive shifter
  logic [7:0] txsh; // transmit shifter
  logic ack_bit; // answer for the byte just taken
  logic rw; // direction of current transfer
  logic tgt_mem; // memory selected
  logic [1:0] byte_idx; // bytes after address, saturating
  logic [7:0] addr_hi; // held high address byte
  logic [15:0] addr_cnt; // memory address counter
  logic [7:0] str_cnt; // stretch timer
  logic str_pend; // block completed, stretch due
  logic [7:0] mem [0:ides_pkg::MEM_BYTES-1]; // memory array

  // synchronised pins
  wire logic pin_fixed = pin_b[0];
  wire logic [5:0] pin_soft = pin_b[6:1];
  wire logic [2:0] pin_cnt = pin_b[9:7];
  wire logic pin_wp = pin_b[10];
  // bus events
  wire logic scl_rise = scl_b & ~scl_q;
  wire logic scl_fall = ~scl_b & scl_q;
  wire logic start_c = scl_b & scl_q & sda_q & ~sda_b;
  wire logic stop_c = scl_b & scl_q & ~sda_q & sda_b;
  wire logic [7:0] nb = {shreg[6:0], sda_b};
  wire logic byte_end = scl_rise & (bit_cnt == ides_pkg::BIT_LAST);
  // address matching
  wire logic [6:0] reg_addr; // register device address, bit-wise assigned
  wire logic [6:0] mem_addr; // memory address, bit-wise assigned
  assign reg_addr[0] = pin_fixed;
  assign mem_addr[0] = pin_fixed;
  genvar k;
  for (k = 1; k <= ides_pkg::SOFT_PINS; k++)
  begin : g_addr
    assign reg_addr[k] = (3'(k) <= pin_cnt) ? pin_soft[k-1] : ides_pkg::REG_TEMPLATE[k];
    assign mem_addr[k] = (3'(k) <= pin_cnt) ? pin_soft[k-1] : ides_pkg::MEM_TEMPLATE[k];
  end
  wire logic shared = (pin_cnt >= ides_pkg::SOFT_ALL);
  wire logic hit_reg = (nb[7:1] == reg_addr);
  wire logic hit_mem = (nb[7:1] == mem_addr);
  wire logic next_tgt = shared ? tgt_mem : hit_mem;
  // memory reach and read data
  wire logic mem_ok = (addr_cnt <= ides_pkg::MEM_LAST);
  wire logic [ides_pkg::MEM_AW-1:0] mem_idx = addr_cnt[ides_pkg::MEM_AW-1:0];
  wire logic [7:0] rd_byte = mem_ok ? mem[mem_idx] : 8'hff;
  wire logic addr_ack = (hit_reg | hit_mem) & ~(nb[0] & next_tgt & ~mem_ok);
  wire logic first_mem = shared ? nb[7] : tgt_mem;
  wire logic rx_ack = (byte_idx != ides_pkg::IDX_DATA) | ~tgt_mem | (mem_ok & ~pin_wp);
  wire logic data_byte = (state == ides_pkg::S_RX) & byte_end & (byte_idx == ides_pkg::IDX_DATA);
  wire logic mem_we = data_byte & tgt_mem & rx_ack;
  wire logic load_tx = scl_fall & rw & ((state == ides_pkg::S_ACK) | (state == ides_pkg::S_MACKF));

  // two-flop synchronisers, plus one delay stage for edge detection
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_a <= 1'b1;
      scl_b <= 1'b1;
      scl_q <= 1'b1;
      sda_a <= 1'b1;
      sda_b <= 1'b1;
      sda_q <= 1'b1;
      pin_a <= 11'h000;
      pin_b <= 11'h000;
    end
    else
    begin
      scl_a <= bus.scl;
      scl_b <= scl_a;
      scl_q <= scl_b;
      sda_a <= bus.sda;
      sda_b <= sda_a;
      sda_q <= sda_b;
      pin_a <= {mem_write_protect_in, soft_pin_count, soft_slave_addr_pins, fixed_slave_addr_pin};
      pin_b <= pin_a;
    end
  end

  // memory write port, no reset on the array
  always_ff @(posedge mclk)
  begin
    if (mem_we)
      mem[mem_idx] <= nb;
  end

  // memory address counter
  always_ff @(posedge mclk)
  begin
    if (rst)
      addr_cnt <= 16'h0000;
    else if ((state == ides_pkg::S_RX) & byte_end & (byte_idx == 2'h1) & tgt_mem)
      addr_cnt <= {addr_hi, nb};
    else if (mem_we | (load_tx & tgt_mem & mem_ok))
      addr_cnt <= addr_cnt + 16'h0001;
  end

  // register device strobes and data
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      reg_ptr <= 8'h00;
      reg_ptr_stb <= 1'b0;
      reg_wr_data <= 8'h00;
      reg_wr_stb <= 1'b0;
      reg_rd_stb <= 1'b0;
    end
    else
    begin
      reg_ptr_stb <= (state == ides_pkg::S_RX) & byte_end & (byte_idx == 2'h0) & ~first_mem;
      if ((state == ides_pkg::S_RX) & byte_end & (byte_idx == 2'h0) & ~first_mem)
        reg_ptr <= nb;
      reg_wr_stb <= (state == ides_pkg::S_RX) & byte_end & (byte_idx != 2'h0) & ~tgt_mem;
      if ((state == ides_pkg::S_RX) & byte_end)
        reg_wr_data <= nb;
      reg_rd_stb <= load_tx & ~tgt_mem;
    end
  end

  // bit-level state machine
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= ides_pkg::S_IDLE;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      ack_bit <= 1'b0;
      rw <= 1'b0;
      tgt_mem <= 1'b0;
      byte_idx <= 2'h0;
      addr_hi <= 8'h00;
      str_cnt <= 8'h00;
      str_pend <= 1'b0;
      bus.s_sda_oe <= 1'b0;
      bus.s_scl_oe <= 1'b0;
      bus.s_sda_out <= 1'b0;
      bus.s_scl_out <= 1'b0;
    end
    // start or repeated start restarts address reception
    else if (start_c)
    begin
      state <= ides_pkg::S_ADDR;
      bit_cnt <= 3'h0;
      str_pend <= 1'b0;
      bus.s_sda_oe <= 1'b0;
    end
    // stop frees the bus
    else if (stop_c)
    begin
      state <= ides_pkg::S_IDLE;
      str_pend <= 1'b0;
      bus.s_sda_oe <= 1'b0;
    end
    else
    begin
      case (state)
        // receive address or data bits on rising scl
        ides_pkg::S_ADDR, ides_pkg::S_RX:
        begin
          if (scl_rise)
          begin
            shreg <= nb;
            bit_cnt <= bit_cnt + 3'h1;
          end
          if (byte_end & (state == ides_pkg::S_ADDR))
          begin
            state <= ides_pkg::S_ACKW;
            ack_bit <= addr_ack;
            rw <= nb[0];
            tgt_mem <= next_tgt;
            byte_idx <= 2'h0;
          end
          else if (byte_end)
          begin
            state <= ides_pkg::S_ACKW;
            ack_bit <= rx_ack;
            if (byte_idx != ides_pkg::IDX_DATA)
              byte_idx <= byte_idx + 2'h1;
            if (byte_idx == 2'h0)
              tgt_mem <= first_mem;
            if (byte_idx == 2'h0)
              addr_hi <= shared ? {1'b0, nb[6:0]} : nb;
            if (mem_we)
              str_pend <= (addr_cnt[5:0] == ides_pkg::PAGE_LAST);
          end
        end
        // drive the answer once scl is low
        ides_pkg::S_ACKW:
        begin
          if (scl_fall)
          begin
            bus.s_sda_oe <= ack_bit;
            state <= ack_bit ? ides_pkg::S_ACK : ides_pkg::S_IGN;
          end
        end
        // end of answer slot or master ack: send, stretch or receive
        ides_pkg::S_ACK, ides_pkg::S_MACKF:
        begin
          if (scl_fall)
          begin
            bit_cnt <= 3'h0;
            if (rw)
            begin
              state <= ides_pkg::S_TX;
              txsh <= tgt_mem ? rd_byte : reg_rd_data;
              bus.s_sda_oe <= tgt_mem ? ~rd_byte[7] : ~reg_rd_data[7];
            end
            else if (str_pend)
            begin
              bus.s_sda_oe <= 1'b0;
              bus.s_scl_oe <= 1'b1;
              str_cnt <= 8'h00;
              str_pend <= 1'b0;
              state <= ides_pkg::S_STR;
            end
            else
            begin
              bus.s_sda_oe <= 1'b0;
              state <= ides_pkg::S_RX;
            end
          end
        end
        // commit time, then release scl
        ides_pkg::S_STR:
        begin
          str_cnt <= str_cnt + 8'h01;
          if (str_cnt == ides_pkg::STRETCH_CYC - 8'h01)
          begin
            bus.s_scl_oe <= 1'b0;
            state <= ides_pkg::S_RX;
          end
        end
        // shift out on falling scl
        ides_pkg::S_TX:
        begin
          if (scl_fall & (bit_cnt == ides_pkg::BIT_LAST))
          begin
            bus.s_sda_oe <= 1'b0;
            state <= ides_pkg::S_MACK;
          end
          else if (scl_fall)
          begin
            txsh <= {txsh[6:0], 1'b0};
            bus.s_sda_oe <= ~txsh[6];
            bit_cnt <= bit_cnt + 3'h1;
          end
        end
        // master ack ends or continues the read
        ides_pkg::S_MACK:
        begin
          if (scl_rise)
            state <= sda_b ? ides_pkg::S_IGN : ides_pkg::S_MACKF;
        end
        // idle or ignoring until start or stop
        default:
        begin
          bus.s_sda_oe <= 1'b0;
        end
      endcase
    end
  end
endmodule : ides_slave
`default_nettype wire

// *** hw/ides_pkg.sv ***
// ides_pkg: constants and types shared by both ends of the dual slave link
// assumes a 20 MHz mclk on both ends and an open-drain two-wire bus
package ides_pkg;
  // clock figures
  localparam int CLK_NS = 50;
  localparam int SCL_PERIOD_NS = 400;
  localparam logic [2:0] HALF_CYC = 3'(SCL_PERIOD_NS / (2 * CLK_NS));
  localparam logic [2:0] SDA_SET = 3'h1;
  // clock stretch while a finished 64-byte block is committed
  localparam int STRETCH_NS = 5000;
  localparam logic [7:0] STRETCH_CYC = 8'((STRETCH_NS + CLK_NS - 1) / CLK_NS);
  // slave address templates, bit 0 is replaced by the fixed pin
  localparam logic [6:0] REG_TEMPLATE = 7'h20;
  localparam logic [6:0] MEM_TEMPLATE = 7'h50;
  localparam int SOFT_PINS = 6;
  localparam logic [2:0] SOFT_ALL = 3'h6;
  // memory space
  localparam int MEM_AW = 9;
  localparam int MEM_BYTES = 512;
  localparam logic [15:0] MEM_LAST = 16'h01ff;
  localparam logic [5:0] PAGE_LAST = 6'h3f;
  // byte framing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] SLOT_ACK = 4'h8;
  localparam logic [1:0] IDX_DATA = 2'h2;
  // slave bit-level states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_ADDR = 4'h1, S_RX = 4'h2, S_ACKW = 4'h3, S_ACK = 4'h4,
    S_STR = 4'h5, S_TX = 4'h6, S_MACK = 4'h7, S_MACKF = 4'h8, S_IGN = 4'h9
  } ides_slave_e;
  // master commands
  typedef enum logic [1:0] {
    OP_START = 2'h0, OP_WRITE = 2'h1, OP_READ = 2'h2, OP_STOP = 2'h3
  } ides_op_e;
  // master states
  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_START = 3'h1, M_BLO = 3'h2, M_BHI = 3'h3, M_STOP = 3'h4
  } ides_mst_e;
endpackage : ides_pkg

// *** hw/ides_if.sv ***
// ides_if: the two-wire bus between master and slave
// assumes each end pulls a line low by raising its enable; lines idle high
`timescale 1ns/1ps
`default_nettype none
interface ides_if;
  // master drive
  logic m_scl_out;
  logic m_scl_oe;
  logic m_sda_out;
  logic m_sda_oe;
  // slave drive
  logic s_scl_out;
  logic s_scl_oe;
  logic s_sda_out;
  logic s_sda_oe;
  // resolved wired-and levels with pull-up
  wire logic scl;
  wire logic sda;
  assign scl = ~((m_scl_oe & ~m_scl_out) | (s_scl_oe & ~s_scl_out));
  assign sda = ~((m_sda_oe & ~m_sda_out) | (s_sda_oe & ~s_sda_out));
  modport dev (input scl, input sda, output s_scl_out, output s_scl_oe, output s_sda_out, output s_sda_oe);
  modport host (input scl, input sda, output m_scl_out, output m_scl_oe, output m_sda_out, output m_sda_oe);
endinterface : ides_if
`default_nettype wire

// *** hw/ides_master.sv ***
// ides_master: byte-level master that makes scl by dividing mclk
// assumes one command at a time; slave may stretch scl while released
`timescale 1ns/1ps
`default_nettype none
module ides_master (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // bus
  ides_if.host bus,
  // command port
  input wire logic cmd_valid,
  input wire ides_pkg::ides_op_e cmd_op,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_ack,
  output logic cmd_ready,
  // response port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_nack
);
  ides_pkg::ides_mst_e state; // sequencer state
  logic scl_a, scl_b; // scl sync
  logic sda_a, sda_b; // sda sync
  logic [1:0] ph; // phase within start or stop
  logic [2:0] tcnt; // half-period timer
  logic [3:0] slot; // bit slot within byte
  logic [8:0] txbits; // bits to put on sda
  logic [7:0] rxsh; // bits sampled from sda

  // released scl must really be high before the timer runs (stretch)
  wire logic wait_hi = (state == ides_pkg::M_BHI) |
                       (((state == ides_pkg::M_START) | (state == ides_pkg::M_STOP)) & (ph == 2'h1));
  wire logic hold = wait_hi & ~scl_b;
  wire logic tdone = (tcnt == ides_pkg::HALF_CYC - 3'h1);
  wire logic step = tdone & ~hold & (state != ides_pkg::M_IDLE);

  // synchronisers and timer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      scl_a <= 1'b1;
      scl_b <= 1'b1;
      sda_a <= 1'b1;
      sda_b <= 1'b1;
      tcnt <= 3'h0;
    end
    else
    begin
      scl_a <= bus.scl;
      scl_b <= scl_a;
      sda_a <= bus.sda;
      sda_b <= sda_a;
      tcnt <= ((state == ides_pkg::M_IDLE) | hold | tdone) ? 3'h0 : tcnt + 3'h1;
    end
  end

  // sequencer
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      state <= ides_pkg::M_IDLE;
      ph <= 2'h0;
      slot <= 4'h0;
      txbits <= 9'h1ff;
      rxsh <= 8'h00;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_nack <= 1'b0;
      bus.m_scl_oe <= 1'b0;
      bus.m_sda_oe <= 1'b0;
      bus.m_scl_out <= 1'b0;
      bus.m_sda_out <= 1'b0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      case (state)
        // take a command
        ides_pkg::M_IDLE:
        begin
          if (cmd_valid & cmd_ready)
          begin
            cmd_ready <= 1'b0;
            ph <= 2'h0;
            slot <= 4'h0;
            txbits <= (cmd_op == ides_pkg::OP_READ) ? {8'hff, ~cmd_ack} : {cmd_data, 1'b1};
            if (cmd_op == ides_pkg::OP_START)
              state <= ides_pkg::M_START;
            else if (cmd_op == ides_pkg::OP_STOP)
              state <= ides_pkg::M_STOP;
            else
              state <= ides_pkg::M_BLO;
            // start releases sda, stop pulls it low while scl is low
            if (cmd_op == ides_pkg::OP_START)
              bus.m_sda_oe <= 1'b0;
            else if (cmd_op == ides_pkg::OP_STOP)
              bus.m_sda_oe <= 1'b1;
          end
        end
        // release scl, drop sda while high, then pull scl low
        ides_pkg::M_START:
        begin
          if (step)
          begin
            ph <= ph + 2'h1;
            if (ph == 2'h0)
              bus.m_scl_oe <= 1'b0;
            else if (ph == 2'h1)
              bus.m_sda_oe <= 1'b1;
            else
            begin
              bus.m_scl_oe <= 1'b1;
              state <= ides_pkg::M_IDLE;
              cmd_ready <= 1'b1;
              rsp_valid <= 1'b1;
              rsp_nack <= 1'b0;
            end
          end
        end
        // release scl, then release sda while high
        ides_pkg::M_STOP:
        begin
          if (step)
          begin
            ph <= ph + 2'h1;
            if (ph == 2'h0)
              bus.m_scl_oe <= 1'b0;
            else if (ph == 2'h1)
              bus.m_sda_oe <= 1'b0;
            else
            begin
              state <= ides_pkg::M_IDLE;
              cmd_ready <= 1'b1;
              rsp_valid <= 1'b1;
              rsp_nack <= 1'b0;
            end
          end
        end
        // scl low: set sda shortly after the fall, then release scl
        ides_pkg::M_BLO:
        begin
          bus.m_scl_oe <= 1'b1;
          if (tcnt == ides_pkg::SDA_SET)
            bus.m_sda_oe <= ~txbits[8];
          if (step)
          begin
            bus.m_scl_oe <= 1'b0;
            state <= ides_pkg::M_BHI;
          end
        end
        // scl high: sample at the end of the high half
        ides_pkg::M_BHI:
        begin
          if (step)
          begin
            bus.m_scl_oe <= 1'b1;
            if (slot == ides_pkg::SLOT_ACK)
            begin
              rsp_nack <= sda_b;
              rsp_data <= rxsh;
              rsp_valid <= 1'b1;
              cmd_ready <= 1'b1;
              state <= ides_pkg::M_IDLE;
            end
            else
            begin
              rxsh <= {rxsh[6:0], sda_b};
              txbits <= {txbits[7:0], 1'b1};
              slot <= slot + 4'h1;
              state <= ides_pkg::M_BLO;
            end
          end
        end
        default:
        begin
          state <= ides_pkg::M_IDLE;
          cmd_ready <= 1'b1;
        end
      endcase
    end
  end
endmodule : ides_master
`default_nettype wire

// *** dv/ides_asserts.sv ***
// ides_asserts: wire-level checks on the two-wire bus between both ends
// assumes it is instantiated beside the interface that joins the two ends
`timescale 1ns/1ps
`default_nettype none
module ides_asserts (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // resolved lines
  input wire logic scl,
  input wire logic sda,
  // master drive
  input wire logic m_scl_out,
  input wire logic m_scl_oe,
  input wire logic m_sda_out,
  input wire logic m_sda_oe,
  // slave drive
  input wire logic s_scl_out,
  input wire logic s_scl_oe,
  input wire logic s_sda_out,
  input wire logic s_sda_oe
);
  // cycles the slave has held scl low so far
  logic [7:0] str_cnt;
  // counts a stretch, clears once scl is let go
  always_ff @(posedge mclk)
  begin
    if (rst)
      str_cnt <= 8'h00;
    else
      str_cnt <= s_scl_oe ? str_cnt + 8'h01 : 8'h00;
  end
  // one clock domain for all checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);
  // a stretch lasts exactly the commit time
  a_stretch_len: assert property ($fell(s_scl_oe) |-> str_cnt == ides_pkg::STRETCH_CYC)
    else $error("stretch length wrong");
  a_stretch_max: assert property (s_scl_oe |-> str_cnt < ides_pkg::STRETCH_CYC)
    else $error("stretch too long");
  // stretch only begins while the master holds scl low
  a_stretch_start: assert property ($rose(s_scl_oe) |-> m_scl_oe && !scl)
    else $error("stretch started with scl high");
  a_stretch_hold: assert property ($rose(s_scl_oe) |=> s_scl_oe [*8])
    else $error("stretch dropped early");
  // slave moves sda only while scl is low, never forging start or stop
  a_sda_change_low: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("slave moved sda with scl high");
  // slave never holds sda for ever
  a_sda_hold_bound: assert property ($rose(s_sda_oe) |-> ##[1:300] !s_sda_oe)
    else $error("slave holds sda");
  // both ends only ever pull low
  a_slave_sda_od: assert property (s_sda_oe |-> !s_sda_out && !sda)
    else $error("slave drives sda high");
  a_slave_scl_od: assert property (s_scl_oe |-> !s_scl_out)
    else $error("slave drives scl high");
  a_master_sda_od: assert property (m_sda_oe |-> !m_sda_out)
    else $error("master drives sda high");
  a_master_scl_od: assert property (m_scl_oe |-> !m_scl_out)
    else $error("master drives scl high");
endmodule : ides_asserts
`default_nettype wire

// *** dv/testbench.sv ***
// testbench: both ends joined over the bus, user sides driven and judged
// assumes the package, interface, both ends and the checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // clock, reset, tallies
  logic mclk;
  logic rst;
  int cycles;
  int errors;
  int checked;
  logic seen_str;
  // master command side
  logic cmd_valid;
  ides_pkg::ides_op_e cmd_op;
  logic [7:0] cmd_data;
  logic cmd_ack;
  logic cmd_ready;
  logic rsp_valid;
  logic [7:0] rsp_data;
  logic rsp_nack;
  // slave straps and register side
  logic fixed_slave_addr_pin;
  logic [5:0] soft_slave_addr_pins;
  logic [2:0] soft_pin_count;
  logic mem_write_protect_in;
  logic [7:0] reg_ptr;
  logic [7:0] reg_wr_data;
  logic [7:0] reg_rd_data;
  // register side strobes and their pulse counts
  logic reg_ptr_stb;
  logic reg_wr_stb;
  logic reg_rd_stb;
  int n_ptr;
  int n_wr;
  int n_rd;
  // last answer of the master
  logic nk;
  logic [7:0] rd;
  ides_if bus ();
  ides_master ides_master_inst (.mclk(mclk), .rst(rst), .bus(bus), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_data(cmd_data), .cmd_ack(cmd_ack), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_nack(rsp_nack));
  ides_slave ides_slave_inst (.mclk(mclk), .rst(rst), .bus(bus), .fixed_slave_addr_pin(fixed_slave_addr_pin),
    .soft_slave_addr_pins(soft_slave_addr_pins), .soft_pin_count(soft_pin_count),
    .mem_write_protect_in(mem_write_protect_in), .reg_ptr(reg_ptr), .reg_ptr_stb(reg_ptr_stb),
    .reg_wr_data(reg_wr_data), .reg_wr_stb(reg_wr_stb), .reg_rd_data(reg_rd_data), .reg_rd_stb(reg_rd_stb));
  ides_asserts ides_asserts_inst (.mclk(mclk), .rst(rst), .scl(bus.scl), .sda(bus.sda),
    .m_scl_out(bus.m_scl_out), .m_scl_oe(bus.m_scl_oe), .m_sda_out(bus.m_sda_out), .m_sda_oe(bus.m_sda_oe),
    .s_scl_out(bus.s_scl_out), .s_scl_oe(bus.s_scl_oe), .s_sda_out(bus.s_sda_out), .s_sda_oe(bus.s_sda_oe));
  // free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // cycle ceiling and stretch watch
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    n_ptr <= n_ptr + int'(reg_ptr_stb);
    n_wr <= n_wr + int'(reg_wr_stb);
    n_rd <= n_rd + int'(reg_rd_stb);
    if (bus.s_scl_oe)
      seen_str <= 1'b1;
    if (cycles == 40000)
    begin
      errors = errors + 1;
      $display("[FAIL] %0t run too long", $time);
      end_sim();
    end
  end
  // one comparison, counted
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk
  // one master command, waits for its answer
  task automatic go(input ides_pkg::ides_op_e op, input logic [7:0] d, input logic ak);
    int n;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_data = d;
    cmd_ack = ak;
    @(negedge mclk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
    chk(rsp_valid === 1'b1, "no response");
    nk = rsp_nack;
    rd = rsp_data;
  endtask : go
  // byte-level helpers
  task automatic sta();
    go(ides_pkg::OP_START, 8'h00, 1'b0);
  endtask : sta
  task automatic sto();
    go(ides_pkg::OP_STOP, 8'h00, 1'b0);
  endtask : sto
  task automatic wr(input logic [7:0] d, input logic exp);
    go(ides_pkg::OP_WRITE, d, 1'b0);
    chk(nk === exp, "ack mismatch");
  endtask : wr
  task automatic rdb(input logic ak, input logic [7:0] exp);
    go(ides_pkg::OP_READ, 8'h00, ak);
    chk(rd === exp, "read data mismatch");
  endtask : rdb
  // start, memory address byte, then both counter bytes
  task automatic mem_at(input logic [6:0] a, input logic [15:0] ad);
    sta();
    wr({a, 1'b0}, 1'b0);
    wr(ad[15:8], 1'b0);
    wr(ad[7:0], 1'b0);
  endtask : mem_at
  // register device: pointer, write, read, foreign address
  task automatic t_reg();
    sta();
    wr(8'h42, 1'b0);
    wr(8'h2e, 1'b0);
    chk(reg_ptr === 8'h2e, "pointer");
    wr(8'h5a, 1'b0);
    chk(reg_wr_data === 8'h5a, "register data");
    reg_rd_data = 8'hc3;
    sta();
    wr(8'h43, 1'b0);
    rdb(1'b0, 8'hc3);
    sto();
    sta();
    wr(8'h40, 1'b1);
    sto();
    chk(n_ptr == 1 && n_wr == 1 && n_rd == 1, "register strobes");
  endtask : t_reg
  // block write across a page edge, then read back
  task automatic t_mem();
    seen_str = 1'b0;
    mem_at(7'h51, 16'h003e);
    wr(8'ha1, 1'b0);
    wr(8'hb2, 1'b0);
    wr(8'hc3, 1'b0);
    sto();
    chk(seen_str === 1'b1, "no stretch");
    mem_at(7'h51, 16'h003e);
    sta();
    wr(8'ha3, 1'b0);
    rdb(1'b1, 8'ha1);
    rdb(1'b1, 8'hb2);
    rdb(1'b0, 8'hc3);
    sto();
    // block write started on a page boundary
    mem_at(7'h51, 16'h0080);
    wr(8'h3c, 1'b0);
    sto();
    mem_at(7'h51, 16'h0080);
    sta();
    wr(8'ha3, 1'b0);
    rdb(1'b0, 8'h3c);
    sto();
  endtask : t_mem
  // protect blocks writes, old data reads back once protect is lifted
  task automatic t_prot();
    mem_write_protect_in = 1'b1;
    mem_at(7'h51, 16'h003e);
    wr(8'h55, 1'b1);
    sto();
    mem_write_protect_in = 1'b0;
    mem_at(7'h51, 16'h003e);
    sta();
    wr(8'ha3, 1'b0);
    rdb(1'b0, 8'ha1);
    sto();
  endtask : t_prot
  // last location, then past the end both ways
  task automatic t_end();
    mem_at(7'h51, 16'h01ff);
    wr(8'h77, 1'b0);
    wr(8'h88, 1'b1);
    sto();
    mem_at(7'h51, 16'h01ff);
    sta();
    wr(8'ha3, 1'b0);
    rdb(1'b0, 8'h77);
    sta();
    wr(8'ha3, 1'b1);
    sto();
  endtask : t_end
  // soft pins: two in use, then all six with a shared address
  task automatic t_soft();
    soft_pin_count = 3'h2;
    repeat (4) @(negedge mclk);
    sta();
    wr(8'h42, 1'b1);
    sto();
    sta();
    wr(8'h4e, 1'b0);
    wr(8'h07, 1'b0);
    chk(reg_ptr === 8'h07, "pointer two pins");
    sto();
    sta();
    wr(8'hae, 1'b0);
    sto();
    soft_pin_count = ides_pkg::SOFT_ALL;
    soft_slave_addr_pins = 6'h2a;
    repeat (4) @(negedge mclk);
    sta();
    wr(8'haa, 1'b0);
    wr(8'h12, 1'b0);
    chk(reg_ptr === 8'h12, "shared pointer");
    sto();
    mem_at(7'h55, 16'h8010);
    wr(8'h9d, 1'b0);
    sto();
    mem_at(7'h55, 16'h8010);
    sta();
    wr(8'hab, 1'b0);
    rdb(1'b0, 8'h9d);
    sto();
  endtask : t_soft
  // counts and verdict, ends the run
  task automatic end_sim();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // main sequence
  initial
  begin
    rst = 1'b1;
    cycles = 0;
    errors = 0;
    checked = 0;
    n_ptr = 0;
    n_wr = 0;
    n_rd = 0;
    seen_str = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = ides_pkg::OP_START;
    cmd_data = 8'h00;
    cmd_ack = 1'b0;
    fixed_slave_addr_pin = 1'b1;
    soft_slave_addr_pins = 6'h3f;
    soft_pin_count = 3'h0;
    mem_write_protect_in = 1'b0;
    reg_rd_data = 8'h00;
    repeat (12) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    t_reg();
    t_mem();
    t_prot();
    t_end();
    t_soft();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
